// ### src/motion_seq_defines.vh
// Constants for the motion search sequence control block.
// Notes on behaviour
// [RULE1] Reset must be held low one cycle first.
// [RULE2] Clock keeps running while reset is low.
// [RULE3] Vector 38 or 46 cycles after last pixel.
// [RULE4] Latency 32n+38 or 64n+46 from first pixel.
// [RULE5] One result strobe per start, with vector strobe.
// [RULE6] Freeze high stops the internal clock.
// [RULE7] Freeze of any length loses no pipeline data.
// [RULE8] Pipeline 8x8: right columns come 8 ahead.
// [RULE9] Row end: fill 7 columns from next row.
// [RULE10] Row end: edge limits set to right edge.
// [RULE11] Row start: edge limits set to left edge.
// [RULE12] Picture end: preload first block search window.
// [RULE13] 16 high, first 8 rows: middle, lower bands.
// [RULE14] 16 high, last 8 rows: upper, middle bands.
// [RULE15] Upper and lower bands may share one source.
// [RULE16] 8 high rectangular: two line delays or 3 reads.
// [RULE17] Four sub-windows: eight sequences, no pipelining.
// [RULE18] Sub-window result after 46th cycle of next sequence.
// [RULE19] Four devices in parallel cost two block periods.
// [RULE20] Clip component of -16 to -15.
// [RULE21] Pipelined sub-window pairs cost six block periods.
// [RULE22] Edge limits latched on first sequence cycle.
// [RULE23] Frozen: outputs and counters hold still; the bus slave and frozen_cnt_r keep running.
`ifndef MOTION_SEQ_DEFINES_VH
`define MOTION_SEQ_DEFINES_VH
`define OFS_CONFIG 4'h0
`define OFS_STATUS 4'h4
`define OFS_RESULTS 4'h8
`define OFS_FROZEN 4'hC
`define CFG_WIDTH_LSB 0
`define CFG_WIDTH_MSB 5
`define CFG_WIDTH_RESET 6'h02
`define ST_FROZEN 0
`define ST_H16 1
`define ST_RECT 2
`define ST_BUSY 3
`define ST_EDGE_LSB 4
`define ST_EDGE_MSB 7
`define ST_OVERRUN 8
`define ST_MISSING 9
`define TAIL_H8 13'h0026
`define TAIL_H16 13'h002E
`define SQ_N_H8 6'h02
`define SQ_N_H16 6'h04
`define EDGE_TOP 0
`define EDGE_RIGHT 1
`define EDGE_BOTTOM 2
`define EDGE_LEFT 3
`define VEC_MIN 4'h8
`define VEC_MAX 4'h7
`define VEC_ZERO 4'h0
`endif

// ### src/latency_tracker.v
// Counts out block latencies and strobes when each one expires.
`timescale 1ns/10ps
module latency_tracker #(
   parameter SLOTS = 3,
   parameter W = 13
) (
   // Clock, reset and freeze enable
   input wire clk_sys,
   input wire rst_n,
   input wire en,
   // Start of a timed block and its latency minus one
   input wire start,
   input wire [W-1:0] load_val,
   // Expiry strobe and slot state
   output reg fire_r,
   output wire [SLOTS-1:0] busy,
   output wire overrun
);
   reg [SLOTS-1:0] grant;
   reg taken;
   integer k;
   wire [SLOTS-1:0] due;

   // Three slots cover the worst overlap, 8x4 blocks at n of one.
   always @* begin
      grant = {SLOTS{1'b0}};
      taken = 1'b0;
      for (k = 0; k < SLOTS; k = k + 1) begin
         if (start && !busy[k] && !taken) begin
            grant[k] = 1'b1;
            taken = 1'b1;
         end
      end
   end

   assign overrun = start & ~taken;

   genvar g;
   generate
      for (g = 0; g < SLOTS; g = g + 1) begin : slot
         reg [W-1:0] cnt_r;
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cnt_r <= {W{1'b0}};
            end else if (en) begin // RULE23
               if (grant[g]) begin
                  cnt_r <= load_val; // RULE4
               end else if (cnt_r != {W{1'b0}}) begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
         end
         assign busy[g] = (cnt_r != {W{1'b0}});
         assign due[g] = (cnt_r == {{(W-1){1'b0}}, 1'b1});
      end
   endgenerate

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fire_r <= 1'b0;
      end else if (en) begin // RULE23
         fire_r <= |due; // RULE5
      end
   end
endmodule // latency_tracker

// ### src/seq_position.v
// Tracks the pixel position inside a block and the band selection.
`timescale 1ns/10ps
module seq_position #(
   parameter LW = 12
) (
   // Clock, reset and freeze enable
   input wire clk_sys,
   input wire rst_n,
   input wire en,
   // Block start and the shape of the current block
   input wire start,
   input wire h16,
   input wire rect,
   input wire [LW-1:0] len_m1,
   // Sequence state
   output wire seq_first,
   output wire missing_start,
   output reg band_upper_r,
   output reg band_middle_r,
   output reg band_lower_r
);
   reg [LW-1:0] pos_r;
   reg running_r;
   wire [LW-1:0] pos;
   wire last;

   assign pos = start ? {LW{1'b0}} : pos_r;
   assign last = (pos == len_m1);
   // A rectangular block never opens a sequence without its own start.
   assign seq_first = en & (start |
      (running_r & ~rect & (pos_r == {LW{1'b0}})));
   // Rectangular blocks have no known width, so each needs its own start.
   assign missing_start = en & running_r & rect & ~start &
      (pos_r == {LW{1'b0}});

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pos_r <= {LW{1'b0}};
         running_r <= 1'b0;
         band_upper_r <= 1'b0;
         band_middle_r <= 1'b0;
         band_lower_r <= 1'b0;
      end else if (en) begin // RULE7
         if (start) begin
            running_r <= 1'b1;
         end else if (missing_start) begin
            running_r <= 1'b0;
         end
         if (start || running_r) begin
            pos_r <= last ? {LW{1'b0}} : pos + 1'b1;
            band_middle_r <= 1'b1;
            band_lower_r <= ~h16 | ~pos[3]; // RULE13
            band_upper_r <= ~h16 | pos[3]; // RULE14
         end else begin
            band_middle_r <= 1'b0;
            band_lower_r <= 1'b0;
            band_upper_r <= 1'b0;
         end
      end
   end
endmodule // seq_position

// ### src/motion_search_sequence_control.v
// Sequence, latency and freeze control of the motion search engine.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "motion_seq_defines.vh"
module motion_search_sequence_control #(
   parameter SLOTS = 3,
   parameter LAT_W = 13
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Avalon-MM register slave
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output wire [31:0] readdata,
   output wire waitrequest,
   // Sequence pins
   input wire block_start_strobe_n,
   input wire height16_sel,
   input wire rect_sel,
   input wire [3:0] edge_limit_pins,
   input wire freeze,
   // Result strobes, active low
   output wire result_latency_strobe_n,
   output wire vector_ready_strobe_n,
   // Band use for the pixel taken in the previous cycle
   output wire band_upper_use,
   output wire band_middle_use,
   output wire band_lower_use,
   // Sequence start and the vector range of its search window
   output reg seq_first_r,
   output reg [3:0] edge_limit_r,
   output reg [3:0] horiz_min_r,
   output reg [3:0] horiz_max_r,
   output reg [3:0] vert_min_r,
   output reg [3:0] vert_max_r
);
   // Register state
   reg ack_r;
   reg [31:0] readdata_r;
   reg [5:0] cfg_width_r;
   reg overrun_r;
   reg missing_r;
   reg [15:0] results_r;
   reg [15:0] frozen_cnt_r;
   // Mode latched at the block start
   reg mode_h16_r;
   reg mode_rect_r;
   reg [11:0] mode_len_m1_r;
   // Combinational helpers
   reg [31:0] rd_mux;
   wire en;
   wire start;
   wire [5:0] new_n;
   wire [11:0] new_len;
   wire [LAT_W-1:0] new_lat;
   wire [LAT_W-1:0] new_lat_m1;
   wire [11:0] len_m1;
   wire cur_h16;
   wire cur_rect;
   wire seq_first;
   wire missing_start;
   wire lat_fire;
   wire vec_fire;
   wire [SLOTS-1:0] lat_busy;
   wire [SLOTS-1:0] vec_busy;
   wire lat_overrun;
   wire vec_overrun;
   wire access;
   wire wr_take;
   wire status_wr;

   // The whole sequencing core runs on this enable, so a freeze of any
   // length simply stops it with every stage intact.
   assign en = ~freeze; // RULE6
   assign start = en & ~block_start_strobe_n;

   // Block width in units of four; square blocks have a fixed width.
   assign new_n = rect_sel ? cfg_width_r :
      (height16_sel ? `SQ_N_H16 : `SQ_N_H8);
   assign new_len = height16_sel ? {new_n, 6'h00} : {1'b0, new_n, 5'h00};
   assign new_lat = {1'b0, new_len} +
      (height16_sel ? `TAIL_H16 : `TAIL_H8); // RULE3 RULE18
   assign new_lat_m1 = new_lat - 1'b1; // RULE4
   assign len_m1 = start ? (new_len - 1'b1) : mode_len_m1_r;
   assign cur_h16 = start ? height16_sel : mode_h16_r;
   assign cur_rect = start ? rect_sel : mode_rect_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_h16_r <= 1'b0;
         mode_rect_r <= 1'b0;
         mode_len_m1_r <= 12'h03F;
      end else if (start) begin
         mode_h16_r <= height16_sel;
         mode_rect_r <= rect_sel;
         mode_len_m1_r <= new_len - 1'b1;
      end
   end

   seq_position #(
      .LW(12)
   ) u_pos (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .en(en),
      .start(start),
      .h16(cur_h16),
      .rect(cur_rect),
      .len_m1(len_m1),
      .seq_first(seq_first),
      .missing_start(missing_start),
      .band_upper_r(band_upper_use),
      .band_middle_r(band_middle_use),
      .band_lower_r(band_lower_use)
   );

   // One tracker per start strobe and one per sequence; every strobed
   // sequence is timed by both, so the two strobes fall together.
   latency_tracker #(
      .SLOTS(SLOTS),
      .W(LAT_W)
   ) u_lat (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .en(en),
      .start(start),
      .load_val(new_lat_m1),
      .fire_r(lat_fire),
      .busy(lat_busy),
      .overrun(lat_overrun)
   );

   latency_tracker #(
      .SLOTS(SLOTS),
      .W(LAT_W)
   ) u_vec (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .en(en),
      .start(seq_first),
      .load_val(start ? new_lat_m1 :
         {1'b0, mode_len_m1_r} + (mode_h16_r ? `TAIL_H16 : `TAIL_H8)),
      .fire_r(vec_fire),
      .busy(vec_busy),
      .overrun(vec_overrun)
   );

   assign result_latency_strobe_n = ~lat_fire; // RULE5
   assign vector_ready_strobe_n = ~vec_fire; // RULE5

   // Edge limits belong to the window loaded in this very sequence.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seq_first_r <= 1'b0;
         edge_limit_r <= 4'h0;
         horiz_min_r <= `VEC_MIN;
         horiz_max_r <= `VEC_MAX;
         vert_min_r <= `VEC_MIN;
         vert_max_r <= `VEC_MAX;
      end else if (en) begin // RULE23
         seq_first_r <= seq_first;
         if (seq_first) begin
            edge_limit_r <= edge_limit_pins; // RULE22
            horiz_min_r <= edge_limit_pins[`EDGE_LEFT] ? `VEC_ZERO :
               `VEC_MIN;
            horiz_max_r <= edge_limit_pins[`EDGE_RIGHT] ? `VEC_ZERO :
               `VEC_MAX;
            vert_min_r <= edge_limit_pins[`EDGE_TOP] ? `VEC_ZERO :
               `VEC_MIN;
            vert_max_r <= edge_limit_pins[`EDGE_BOTTOM] ? `VEC_ZERO :
               `VEC_MAX;
         end
      end
   end

   // Bus slave: one wait state, then the answer on the following edge.
   assign access = read | write;
   assign waitrequest = access & ~ack_r;
   assign wr_take = write & ack_r;
   assign status_wr = wr_take & (address == `OFS_STATUS);
   assign readdata = readdata_r;

   always @* begin
      rd_mux = 32'h00000000;
      case (address)
         `OFS_CONFIG: rd_mux[`CFG_WIDTH_MSB:`CFG_WIDTH_LSB] = cfg_width_r;
         `OFS_STATUS: begin
            rd_mux[`ST_FROZEN] = freeze;
            rd_mux[`ST_H16] = mode_h16_r;
            rd_mux[`ST_RECT] = mode_rect_r;
            rd_mux[`ST_BUSY] = |vec_busy;
            rd_mux[`ST_EDGE_MSB:`ST_EDGE_LSB] = edge_limit_r;
            rd_mux[`ST_OVERRUN] = overrun_r;
            rd_mux[`ST_MISSING] = missing_r;
         end
         `OFS_RESULTS: rd_mux[15:0] = results_r;
         `OFS_FROZEN: rd_mux[15:0] = frozen_cnt_r;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         readdata_r <= 32'h00000000;
         cfg_width_r <= `CFG_WIDTH_RESET;
      end else begin
         ack_r <= access & ~ack_r;
         if (read && !ack_r) begin
            readdata_r <= rd_mux;
         end
         if (wr_take && address == `OFS_CONFIG &&
               writedata[`CFG_WIDTH_MSB:`CFG_WIDTH_LSB] != 6'h00) begin
            cfg_width_r <= writedata[`CFG_WIDTH_MSB:`CFG_WIDTH_LSB];
         end
      end
   end

   // Error flags: a new event in the clearing cycle keeps the flag set.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overrun_r <= 1'b0;
         missing_r <= 1'b0;
      end else begin
         if (lat_overrun || vec_overrun) begin
            overrun_r <= 1'b1;
         end else if (status_wr && writedata[`ST_OVERRUN]) begin
            overrun_r <= 1'b0;
         end
         if (missing_start) begin
            missing_r <= 1'b1;
         end else if (status_wr && writedata[`ST_MISSING]) begin
            missing_r <= 1'b0;
         end
      end
   end

   // Counters of delivered vectors and of frozen cycles, both saturating
   // so software never sees a wrap it could mistake for a small count.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         results_r <= 16'h0000;
         frozen_cnt_r <= 16'h0000;
      end else begin
         if (en && vec_fire && results_r != 16'hFFFF) begin
            results_r <= results_r + 1'b1;
         end
         if (freeze && frozen_cnt_r != 16'hFFFF) begin
            frozen_cnt_r <= frozen_cnt_r + 1'b1;
         end
      end
   end
endmodule // motion_search_sequence_control

// ### sim/seq_ctrl_monitor.sv
// Checker of the sequence control block ports.
`timescale 1ns/10ps
module seq_ctrl_monitor (
   // Clock, reset and bus handshake
   input wire clk_sys,
   input wire rst_n,
   input wire read,
   input wire write,
   input wire waitrequest,
   // Sequence pins
   input wire block_start_strobe_n,
   input wire height16_sel,
   input wire rect_sel,
   input wire [3:0] edge_limit_pins,
   input wire freeze,
   // Results
   input wire result_latency_strobe_n,
   input wire vector_ready_strobe_n,
   input wire band_upper_use,
   input wire band_middle_use,
   input wire band_lower_use,
   input wire seq_first_r,
   input wire [3:0] edge_limit_r,
   input wire [3:0] horiz_min_r,
   input wire [3:0] horiz_max_r,
   input wire [3:0] vert_min_r,
   input wire [3:0] vert_max_r
);
   reg [8:0] quiet_r;
   wire start_8x8;
   // Counts unfrozen cycles, so a latency check skips spans with a freeze.
   assign start_8x8 = !block_start_strobe_n && !freeze && !height16_sel &&
      !rect_sel;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) quiet_r <= 9'h000;
      else if (freeze) quiet_r <= 9'h000;
      else if (quiet_r != 9'h1FF) quiet_r <= quiet_r + 9'h001;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   result_vec_a: assert property (
      !result_latency_strobe_n |-> !vector_ready_strobe_n)
      else $error("result strobe without vector strobe");
   lat_8x8_a: assert property (
      start_8x8 ##102 (quiet_r >= 9'h066) |-> !result_latency_strobe_n)
      else $error("8x8 latency missed");
   freeze_hold_a: assert property (
      freeze |=> $stable({result_latency_strobe_n, vector_ready_strobe_n,
      band_upper_use, band_middle_use, band_lower_use, seq_first_r,
      edge_limit_r, horiz_min_r}))
      else $error("state moved while frozen");
   edge_latch_a: assert property (
      seq_first_r && !$past(freeze) |-> edge_limit_r == $past(edge_limit_pins))
      else $error("edge limits not latched");
   range_map_a: assert property (
      horiz_min_r == (edge_limit_r[3] ? 4'h0 : 4'h8) &&
      horiz_max_r == (edge_limit_r[1] ? 4'h0 : 4'h7) &&
      vert_min_r == (edge_limit_r[0] ? 4'h0 : 4'h8) &&
      vert_max_r == (edge_limit_r[2] ? 4'h0 : 4'h7))
      else $error("vector range wrong");
   band_mid_a: assert property (
      (band_upper_use || band_lower_use) |-> band_middle_use)
      else $error("middle band unused");
   strobe_one_a: assert property (
      !result_latency_strobe_n && !freeze |=> result_latency_strobe_n)
      else $error("result strobe too long");
   wait_one_a: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
   cover property (start_8x8);
   cover property (freeze ##1 !freeze);
   cover property (!result_latency_strobe_n);
endmodule // seq_ctrl_monitor
bind motion_search_sequence_control seq_ctrl_monitor i_seq_ctrl_monitor (
   .clk_sys(clk_sys), .rst_n(rst_n), .read(read), .write(write),
   .waitrequest(waitrequest), .block_start_strobe_n(block_start_strobe_n),
   .height16_sel(height16_sel), .rect_sel(rect_sel),
   .edge_limit_pins(edge_limit_pins), .freeze(freeze),
   .result_latency_strobe_n(result_latency_strobe_n),
   .vector_ready_strobe_n(vector_ready_strobe_n),
   .band_upper_use(band_upper_use), .band_middle_use(band_middle_use),
   .band_lower_use(band_lower_use), .seq_first_r(seq_first_r),
   .edge_limit_r(edge_limit_r), .horiz_min_r(horiz_min_r),
   .horiz_max_r(horiz_max_r), .vert_min_r(vert_min_r),
   .vert_max_r(vert_max_r));

// ### sim/pixel_feed_model.sv
// Controller model that opens a block sequence on command.
`timescale 1ns/10ps
module pixel_feed_model (
   // Clock and command
   input wire clk_sys,
   input wire go,
   input wire cmd_h16,
   input wire cmd_rect,
   input wire [3:0] cmd_edges,
   // Sequence pins
   output reg block_start_strobe_n,
   output reg height16_sel,
   output reg rect_sel,
   output reg [3:0] edge_limit_pins
);
   initial begin
      block_start_strobe_n = 1'b1;
      height16_sel = 1'b0;
      rect_sel = 1'b0;
      edge_limit_pins = 4'h0;
   end
   // Mode pins toggle outside the start so a late sample shows up.
   always @(posedge clk_sys) begin
      block_start_strobe_n <= !go;
      height16_sel <= go ? cmd_h16 : !height16_sel;
      rect_sel <= go ? cmd_rect : !rect_sel;
      if (go) edge_limit_pins <= cmd_edges;
   end
endmodule // pixel_feed_model

// ### sim/motion_search_sequence_control_tb_top.sv
// Testbench of the sequence control block.
`timescale 1ns/10ps
module motion_search_sequence_control_tb_top;
   logic clk_sys, rst_n, read, write, freeze, go, cmd_h16, cmd_rect;
   logic [3:0] address, cmd_edges, edge_limit_pins, edge_limit_r;
   logic [3:0] horiz_min_r, horiz_max_r, vert_min_r, vert_max_r;
   logic [31:0] writedata, readdata, d;
   logic waitrequest, block_start_strobe_n, height16_sel, rect_sel;
   logic result_latency_strobe_n, vector_ready_strobe_n, seq_first_r;
   logic band_upper_use, band_middle_use, band_lower_use;
   integer miscompares = 0, total_checks = 0;
   motion_search_sequence_control i_motion_search_sequence_control (
      .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .block_start_strobe_n(block_start_strobe_n),
      .height16_sel(height16_sel), .rect_sel(rect_sel),
      .edge_limit_pins(edge_limit_pins), .freeze(freeze),
      .result_latency_strobe_n(result_latency_strobe_n),
      .vector_ready_strobe_n(vector_ready_strobe_n),
      .band_upper_use(band_upper_use), .band_middle_use(band_middle_use),
      .band_lower_use(band_lower_use), .seq_first_r(seq_first_r),
      .edge_limit_r(edge_limit_r), .horiz_min_r(horiz_min_r),
      .horiz_max_r(horiz_max_r), .vert_min_r(vert_min_r),
      .vert_max_r(vert_max_r));
   pixel_feed_model i_pixel_feed_model (
      .clk_sys(clk_sys), .go(go), .cmd_h16(cmd_h16), .cmd_rect(cmd_rect),
      .cmd_edges(cmd_edges), .block_start_strobe_n(block_start_strobe_n),
      .height16_sel(height16_sel), .rect_sel(rect_sel),
      .edge_limit_pins(edge_limit_pins));
   task test_done;
      begin
         $display("checks %0d miscompares %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task check_val(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
         end
      end
   endtask
   task bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      integer k;
      begin
         k = 0;
         @(posedge clk_sys);
         address <= a;
         writedata <= wd;
         write <= wr;
         read <= !wr;
         do begin
            @(posedge clk_sys);
            k = k + 1;
         end while (waitrequest !== 1'b0 && k < 20);
         d = readdata;
         read <= 1'b0;
         write <= 1'b0;
         if (k >= 20) check_val(32'h0, 32'h1);
      end
   endtask
   task do_reset;
      begin
         @(posedge clk_sys);
         rst_n <= 1'b0;
         repeat (4) @(posedge clk_sys);
         rst_n <= 1'b1;
      end
   endtask
   // Frozen cycles are added to the expected count, so lat is unfrozen.
   task run_block(input logic h16, input logic rect, input logic [3:0] edges,
      input integer frz, input integer lat);
      integer n;
      begin
         n = 0;
         @(posedge clk_sys);
         cmd_h16 <= h16;
         cmd_rect <= rect;
         cmd_edges <= edges;
         go <= 1'b1;
         @(posedge clk_sys);
         go <= 1'b0;
         @(negedge clk_sys);
         while (result_latency_strobe_n !== 1'b0 && n < 500) begin
            @(posedge clk_sys);
            freeze <= (n >= 20 && n < 20 + frz);
            @(negedge clk_sys);
            n = n + 1;
            if (n == 1)
               check_val({seq_first_r, band_upper_use, band_middle_use,
                  band_lower_use},
                  {1'b1, h16 ? 3'b011 : 3'b111});
            if (n == 9)
               check_val({band_upper_use, band_middle_use, band_lower_use},
                  h16 ? 3'b110 : 3'b111);
         end
         check_val(n, lat + frz);
         check_val(vector_ready_strobe_n, 1'b0);
         check_val(edge_limit_r, edges);
         check_val({horiz_min_r, horiz_max_r, vert_min_r, vert_max_r},
            {edges[3] ? 4'h0 : 4'h8, edges[1] ? 4'h0 : 4'h7,
            edges[0] ? 4'h0 : 4'h8, edges[2] ? 4'h0 : 4'h7});
         @(negedge clk_sys);
         check_val(result_latency_strobe_n, 1'b1);
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #40000;
      miscompares = miscompares + 1;
      test_done;
   end
   initial begin
      {rst_n, read, write, freeze, go, cmd_h16, cmd_rect} = 7'h00;
      {address, cmd_edges, writedata} = 40'h0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      bus_xfer(1'b0, 4'h0, 32'h0);
      check_val(d, 32'h2);
      bus_xfer(1'b1, 4'h0, 32'h0);
      bus_xfer(1'b0, 4'h0, 32'h0);
      check_val(d, 32'h2);
      run_block(1'b0, 1'b0, 4'b0010, 0, 102);
      do_reset;
      run_block(1'b0, 1'b0, 4'b1000, 5, 102);
      bus_xfer(1'b0, 4'hC, 32'h0);
      check_val(d, 32'h5);
      do_reset;
      run_block(1'b1, 1'b0, 4'b0000, 0, 302);
      do_reset;
      bus_xfer(1'b1, 4'h0, 32'h3);
      run_block(1'b0, 1'b1, 4'b0101, 0, 134);
      run_block(1'b1, 1'b1, 4'b0100, 0, 238);
      bus_xfer(1'b0, 4'h4, 32'h0);
      check_val(d, 32'h246);
      test_done;
   end
endmodule // motion_search_sequence_control_tb_top
